// ### src/reader_irq_pkg.sv
// shared constants for the reader interrupt request flag unit
package reader_irq_pkg;
    localparam logic [7:0] IRQ_FLAGS_PRIMARY_ADDR    = 8'h06;
    localparam logic [7:0] IRQ_FLAGS_SECONDARY_ADDR  = 8'h07;
    localparam logic [7:0] IRQ_ENABLE_PRIMARY_ADDR   = 8'h08;
    localparam logic [7:0] IRQ_ENABLE_SECONDARY_ADDR = 8'h09;
    localparam int         SET_SELECT_BIT            = 7;
    localparam int         GLOBAL_FLAG_BIT           = 6;
    localparam int         INVERT_BIT                = 7;
    localparam int         PIN_ENABLE_BIT            = 6;
    localparam int         PUSH_PULL_BIT             = 7;
    localparam int         FIFO_HIGH_BIT             = 6;
    localparam int         FIFO_LOW_BIT              = 5;
    localparam int         CMD_DONE_BIT              = 4;
    localparam int         TX_DONE_BIT               = 3;
    localparam int         RX_DONE_BIT               = 2;
    localparam int         ERROR_BIT                 = 1;
    localparam int         SOF_BIT                   = 0;
    localparam int         CARD_DETECT_BIT           = 5;
    localparam logic [6:0] PRIMARY_FLAGS_RESET       = 7'h00;
    localparam logic [5:0] SECONDARY_FLAGS_RESET     = 6'h00;
    localparam logic [7:0] ENABLE_PRIMARY_RESET      = 8'h00;
    localparam logic [7:0] ENABLE_SECONDARY_RESET    = 8'h00;
endpackage

// ### src/reader_irq_flag_unit.sv
// interrupt request flags, enables and interrupt pin drive
`timescale 1ns/1ps
// Contract
// - bit7 chooses set or clear; ones act
// - FFh sets all seven, 7Fh clears all
// - fifo high alert flag latches rising status
// - fifo low alert flag latches rising status
// - command done on self-ending or unknown command
// - host-started idle does not set command done
// - transmit done when last bit sent
// - receive done at stream end, errors regardless
// - error flag from any of five errors
// - start-of-frame flag on sof or subcarrier
// - secondary writes touch bits 5..0 only
// - global flag set when enabled flag active
// - card detect flag on card found
// - timer flags set on timer underflow
// - primary enables gate primary flags to global
// - enable bit7 inverts interrupt pin polarity
// - pin enable lets global reach pin
// - push-pull select, otherwise open-drain
// - secondary enables gate card and timer flags
module reader_irq_flag_unit
    import reader_irq_pkg::*;
(
    // clock and reset
    input  wire logic       core_clk,
    input  wire logic       rstn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output logic      [7:0] regRdata_ff,
    // fifo level status
    input  wire logic       fifoHighLevelStatus,
    input  wire logic       fifoLowLevelStatus,
    // sequencer and transceiver events
    input  wire logic       commandSelfEnd,
    input  wire logic       unknownCommand,
    input  wire logic       hostIdleStart,
    input  wire logic       transmitLastBit,
    input  wire logic       receiveEnd,
    input  wire logic       startOfFrameDetect,
    input  wire logic       subcarrierDetect,
    // error conditions
    input  wire logic       fifoWriteError,
    input  wire logic       fifoOverflowError,
    input  wire logic       protocolError,
    input  wire logic       emptyTransmitError,
    input  wire logic       integrityError,
    // card detect and timers
    input  wire logic       cardDetect,
    input  wire logic [4:0] timerUnderflow,
    // interrupt pin
    output logic            irqPinOut_ff,
    output logic            irqPinOe_ff
);

    // bit positions of the one-hot register select
    localparam int SEL_FLAGS_PRI = 0;
    localparam int SEL_FLAGS_SEC = 1;
    localparam int SEL_EN_PRI    = 2;
    localparam int SEL_EN_SEC    = 3;

    logic [6:0] primaryFlags_ff;
    logic [6:0] nxt_primaryFlags;
    logic [5:0] secondaryFlags_ff;
    logic [5:0] nxt_secondaryFlags;
    logic [7:0] enablePrimary_ff;
    logic [7:0] nxt_enablePrimary;
    logic [7:0] enableSecondary_ff;
    logic [7:0] nxt_enableSecondary;
    logic       globalFlag_ff;
    logic       nxt_globalFlag;
    logic       highLevelPrev_ff;
    logic       lowLevelPrev_ff;
    logic [6:0] primaryEvents;
    logic [5:0] secondaryEvents;
    logic [7:0] nxt_regRdata;
    logic       nxt_irqPinOut;
    logic       nxt_irqPinOe;
    logic       pinLevel;
    logic       nxt_highLevelPrev;
    logic       nxt_lowLevelPrev;
    logic [6:0] enabledPrimary;
    logic [5:0] enabledSecondary;
    logic [3:0] writeSel;
    logic [3:0] readSel;

    // apply a set/clear write to a flag vector; hardware events override a clear
    function automatic logic [6:0] apply_write(input logic [6:0] cur, input logic [6:0] ones,
                                               input logic setMode, input logic [6:0] events);
        logic [6:0] res;
        res = cur;
        if (setMode) begin
            res = cur | ones;
        end else begin
            res = cur & ~ones;
        end
        apply_write = res | events;
    endfunction

    always_comb begin
        primaryEvents = 7'h00;
        primaryEvents[FIFO_HIGH_BIT] = fifoHighLevelStatus & ~highLevelPrev_ff;
        primaryEvents[FIFO_LOW_BIT]  = fifoLowLevelStatus & ~lowLevelPrev_ff;
        // the host idle start blocks only its own cycle's self-end and unknown-command indications
        primaryEvents[CMD_DONE_BIT]  = (commandSelfEnd | unknownCommand) & ~hostIdleStart;
        primaryEvents[TX_DONE_BIT]   = transmitLastBit;
        primaryEvents[RX_DONE_BIT]   = receiveEnd;
        primaryEvents[ERROR_BIT]     = fifoWriteError | fifoOverflowError | protocolError
                                     | emptyTransmitError | integrityError;
        primaryEvents[SOF_BIT]       = startOfFrameDetect | subcarrierDetect;
        secondaryEvents = {cardDetect, timerUnderflow};
    end

    // one-hot register select, shared by the write and the read path
    function automatic logic [3:0] decode_select(input logic [7:0] addr);
        logic [3:0] sel;
        sel = 4'h0;
        case (addr)
            IRQ_FLAGS_PRIMARY_ADDR:    sel[SEL_FLAGS_PRI] = 1'b1;
            IRQ_FLAGS_SECONDARY_ADDR:  sel[SEL_FLAGS_SEC] = 1'b1;
            IRQ_ENABLE_PRIMARY_ADDR:   sel[SEL_EN_PRI]    = 1'b1;
            IRQ_ENABLE_SECONDARY_ADDR: sel[SEL_EN_SEC]    = 1'b1;
            default:                   sel = 4'h0;
        endcase
        decode_select = sel;
    endfunction

    // pin value and enable; open drain only ever pulls low, the board pulls high
    function automatic logic [1:0] pin_drive(input logic level, input logic pushPull);
        logic [1:0] outOe;
        outOe = 2'b00;
        if (pushPull) begin
            outOe = {level, 1'b1};
        end else begin
            outOe = {1'b0, ~level};
        end
        pin_drive = outOe;
    endfunction

    always_comb begin
        writeSel = regWrite ? decode_select(regAddr) : 4'h0;
        readSel  = regRead ? decode_select(regAddr) : 4'h0;
    end

    // primary request flags
    always_comb begin
        nxt_primaryFlags = primaryFlags_ff | primaryEvents;
        if (writeSel[SEL_FLAGS_PRI]) begin
            nxt_primaryFlags = apply_write(primaryFlags_ff, regWdata[6:0],
                                           regWdata[SET_SELECT_BIT], primaryEvents);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            primaryFlags_ff <= PRIMARY_FLAGS_RESET;
        end else begin
            primaryFlags_ff <= nxt_primaryFlags;
        end
    end

    // secondary flags; bit 6 of the write is ignored, the global flag is hardware only
    always_comb begin
        nxt_secondaryFlags = secondaryFlags_ff | secondaryEvents;
        if (writeSel[SEL_FLAGS_SEC]) begin
            nxt_secondaryFlags = 6'(apply_write({1'b0, secondaryFlags_ff},
                                                {1'b0, regWdata[5:0]},
                                                regWdata[SET_SELECT_BIT],
                                                {1'b0, secondaryEvents}));
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            secondaryFlags_ff <= SECONDARY_FLAGS_RESET;
        end else begin
            secondaryFlags_ff <= nxt_secondaryFlags;
        end
    end

    // primary enables, bit 7 doubles as pin inversion
    always_comb begin
        nxt_enablePrimary = enablePrimary_ff;
        if (writeSel[SEL_EN_PRI]) begin
            nxt_enablePrimary = regWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            enablePrimary_ff <= ENABLE_PRIMARY_RESET;
        end else begin
            enablePrimary_ff <= nxt_enablePrimary;
        end
    end

    // secondary enables, upper two bits steer the pin
    always_comb begin
        nxt_enableSecondary = enableSecondary_ff;
        if (writeSel[SEL_EN_SEC]) begin
            nxt_enableSecondary = regWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            enableSecondary_ff <= ENABLE_SECONDARY_RESET;
        end else begin
            enableSecondary_ff <= nxt_enableSecondary;
        end
    end

    // last fifo levels; reset low matches the idle status, so no false edge
    always_comb begin
        nxt_highLevelPrev = fifoHighLevelStatus;
        nxt_lowLevelPrev  = fifoLowLevelStatus;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            highLevelPrev_ff <= 1'b0;
            lowLevelPrev_ff  <= 1'b0;
        end else begin
            highLevelPrev_ff <= nxt_highLevelPrev;
            lowLevelPrev_ff  <= nxt_lowLevelPrev;
        end
    end

    // per-flag enable gating
    for (genvar i = 0; i < 7; i++) begin : g_primary_gate
        assign enabledPrimary[i] = primaryFlags_ff[i] & enablePrimary_ff[i];
    end
    for (genvar j = 0; j < 6; j++) begin : g_secondary_gate
        assign enabledSecondary[j] = secondaryFlags_ff[j] & enableSecondary_ff[j];
    end

    // recomputed from the current flags every clock, so it drops once nothing enabled is set
    always_comb begin
        nxt_globalFlag = (|enabledPrimary) | (|enabledSecondary);
    end

    // global request
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            globalFlag_ff <= 1'b0;
        end else begin
            globalFlag_ff <= nxt_globalFlag;
        end
    end

    // logical pin level first, then the drive mode; the pin lags the flag by two clocks
    always_comb begin
        pinLevel = (globalFlag_ff & enableSecondary_ff[PIN_ENABLE_BIT])
                 ^ enablePrimary_ff[INVERT_BIT];
        {nxt_irqPinOut, nxt_irqPinOe} = pin_drive(pinLevel,
                                                  enableSecondary_ff[PUSH_PULL_BIT]);
    end

    // interrupt pin
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            irqPinOut_ff <= 1'b0;
            irqPinOe_ff  <= 1'b0;
        end else begin
            irqPinOut_ff <= nxt_irqPinOut;
            irqPinOe_ff  <= nxt_irqPinOe;
        end
    end

    // read data holds between reads
    always_comb begin
        nxt_regRdata = regRdata_ff;
        if (regRead) begin
            if (readSel[SEL_FLAGS_PRI]) begin
                nxt_regRdata = {1'b0, primaryFlags_ff};
            end else if (readSel[SEL_FLAGS_SEC]) begin
                nxt_regRdata = {1'b0, globalFlag_ff, secondaryFlags_ff};
            end else if (readSel[SEL_EN_PRI]) begin
                nxt_regRdata = enablePrimary_ff;
            end else if (readSel[SEL_EN_SEC]) begin
                nxt_regRdata = enableSecondary_ff;
            end else begin
                // unmapped addresses read as zero
                nxt_regRdata = 8'h00;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            regRdata_ff <= 8'h00;
        end else begin
            regRdata_ff <= nxt_regRdata;
        end
    end

endmodule // reader_irq_flag_unit

// ### testbench/reader_irq_flag_unit_asserts.sv
// port-level assertions for the interrupt flag unit
`timescale 1ns/1ps
module reader_irq_flag_unit_asserts (
    input wire logic       core_clk,
    input wire logic       rstn,
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata_ff,
    input wire logic       fifoHighLevelStatus,
    input wire logic       cardDetect,
    input wire logic [4:0] timerUnderflow,
    input wire logic       irqPinOut_ff,
    input wire logic       irqPinOe_ff
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    wire rd6 = regRead && regAddr == 8'h06;
    wire rd7 = regRead && regAddr == 8'h07;
    wire wr6 = regWrite && regAddr == 8'h06;
    wire wr7 = regWrite && regAddr == 8'h07;
    a_select_reads_zero: assert property ((rd6 || rd7) |=> !regRdata_ff[7])
        else $error("select bit read as one");
    a_set_all_flags: assert property (wr6 && regWdata == 8'hff ##1 rd6 |=> regRdata_ff == 8'h7f)
        else $error("full set write lost a flag");
    a_written_ones_set: assert property (wr6 && regWdata[7] ##1 rd6
        |=> &(regRdata_ff[6:0] | ~$past(regWdata[6:0], 2))) else $error("set write missed");
    a_secondary_set_mask: assert property (wr7 && regWdata == 8'hff ##1 rd7
        |=> regRdata_ff[5:0] == 6'h3f) else $error("secondary set write missed");
    a_high_alert_latch: assert property ($rose(fifoHighLevelStatus) ##1 rd6
        |=> regRdata_ff[6]) else $error("high alert not latched");
    a_card_flag_set: assert property (cardDetect ##1 rd7 |=> regRdata_ff[5])
        else $error("card flag not set");
    a_timer_flag_set: assert property (timerUnderflow[4] ##1 rd7 |=> regRdata_ff[4])
        else $error("timer flag not set");
    a_drain_drives_low: assert property (irqPinOut_ff |-> irqPinOe_ff)
        else $error("high output while released");
endmodule // reader_irq_flag_unit_asserts
bind reader_irq_flag_unit reader_irq_flag_unit_asserts i_reader_irq_flag_unit_asserts (.core_clk,
    .rstn, .regAddr, .regWrite, .regRead, .regWdata, .regRdata_ff, .fifoHighLevelStatus,
    .cardDetect, .timerUnderflow, .irqPinOut_ff, .irqPinOe_ff);

// ### testbench/irq_pin_host.sv
// host side of the interrupt pin with its pull-up
`timescale 1ns/1ps
module irq_pin_host (
    // pin as driven by the device
    input  wire logic irqPinOut_ff,
    input  wire logic irqPinOe_ff,
    // level the host sees
    output wire logic pinLevel
);
    // a released open-drain line is pulled high on the board
    assign pinLevel = irqPinOe_ff ? irqPinOut_ff : 1'b1;
endmodule // irq_pin_host

// ### testbench/reader_irq_flag_unit_tb.sv
// self-checking bench for the interrupt flag unit
`timescale 1ns/1ps
module reader_irq_flag_unit_tb;
    logic        core_clk, rstn, regWrite, regRead, idleStart;
    logic [7:0]  regAddr, regWdata;
    logic [12:0] ev;
    logic [5:0]  sec;
    wire  [7:0]  regRdata_ff;
    wire         irqPinOut_ff, irqPinOe_ff, pinLevel;
    int          fail_count = 0, compares = 0;
    int          bitOf [13] = '{6, 5, 4, 4, 3, 2, 0, 0, 1, 1, 1, 1, 1};
    reader_irq_flag_unit i_reader_irq_flag_unit (.core_clk, .rstn, .regAddr, .regWrite, .regRead,
        .regWdata, .regRdata_ff, .fifoHighLevelStatus(ev[0]), .fifoLowLevelStatus(ev[1]),
        .commandSelfEnd(ev[2]), .unknownCommand(ev[3]), .hostIdleStart(idleStart),
        .transmitLastBit(ev[4]), .receiveEnd(ev[5]), .startOfFrameDetect(ev[6]),
        .subcarrierDetect(ev[7]), .fifoWriteError(ev[8]), .fifoOverflowError(ev[9]),
        .protocolError(ev[10]), .emptyTransmitError(ev[11]), .integrityError(ev[12]),
        .cardDetect(sec[5]), .timerUnderflow(sec[4:0]), .irqPinOut_ff, .irqPinOe_ff);
    irq_pin_host i_irq_pin_host (.irqPinOut_ff, .irqPinOe_ff, .pinLevel);
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    task automatic tick(input int n = 1);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        tick();
        regWrite = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regAddr = a;
        regRead = 1'b1;
        tick();
        regRead = 1'b0;
        chk($sformatf("register %h", a), exp, regRdata_ff);
    endtask
    // pin checked three cycles after the two enable writes
    task automatic pin(input logic exp, input logic [7:0] en0, input logic [7:0] en1);
        wr(8'h08, en0);
        wr(8'h09, en1);
        tick(3);
        chk("pin level", {7'h00, exp}, {7'h00, pinLevel});
    endtask
    task automatic tally_and_finish;
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        {ev, sec, idleStart, regWrite, regRead, regAddr, regWdata} = '0;
        rstn = 1'b0;
        tick(3);
        rstn = 1'b1;
        for (int a = 6; a < 11; a++) rd(8'(a), 8'h00);
        wr(8'h0a, 8'hff);
        rd(8'h0a, 8'h00);
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h7f);
        wr(8'h06, 8'h7f);
        rd(8'h06, 8'h00);
        wr(8'h06, 8'h85);
        rd(8'h06, 8'h05);
        wr(8'h06, 8'h04);
        rd(8'h06, 8'h01);
        wr(8'h07, 8'hff);
        rd(8'h07, 8'h3f);
        wr(8'h07, 8'h5e);
        rd(8'h07, 8'h21);
        wr(8'h07, 8'h3f);
        wr(8'h06, 8'h7f);
        for (int i = 0; i < 13; i++) begin
            ev[i] = 1'b1;
            tick();
            ev = '0;
            rd(8'h06, 8'h01 << bitOf[i]);
            wr(8'h06, 8'h7f);
        end
        ev[2] = 1'b1;
        idleStart = 1'b1;
        tick();
        {ev, idleStart} = '0;
        rd(8'h06, 8'h00);
        for (int i = 0; i < 6; i++) begin
            sec[i] = 1'b1;
            tick();
            sec = '0;
            rd(8'h07, 8'h01 << i);
            wr(8'h07, 8'h3f);
        end
        wr(8'h06, 8'h88);
        pin(1'b1, 8'h08, 8'hc0);
        rd(8'h07, 8'h40);
        pin(1'b0, 8'h88, 8'hc0);
        pin(1'b0, 8'h08, 8'h80);
        pin(1'b1, 8'h08, 8'h40);
        chk("pin enable", 8'h00, {7'h00, irqPinOe_ff});
        pin(1'b0, 8'h00, 8'h40);
        rd(8'h07, 8'h00);
        wr(8'h06, 8'h08);
        wr(8'h07, 8'h81);
        pin(1'b1, 8'h00, 8'hc1);
        rd(8'h09, 8'hc1);
        wr(8'h07, 8'h01);
        pin(1'b0, 8'h00, 8'hc1);
        tally_and_finish();
    end
endmodule // reader_irq_flag_unit_tb
